// ---- include/gpio_port_defs.svh ----
// register offsets, reset values and field positions for the muxed io port
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

`define PORT_ADDR_W        16
`define PIN_DIRECTION_ADDR 16'hffb5
`define PIN_DATA_ADDR      16'hffb7
`define PIN_DIRECTION_RST  8'h00
`define PIN_DATA_RST       8'h00
`define DIRECTION_READ_VAL 8'hff
`define UNMAPPED_READ_VAL  8'h00
`define HOST_IRQ_LO_PIN    3
`define HOST_IRQ_HI_PIN    5
`define HOST_IRQ_PINS      3
`define TIMER0_CLK_PIN     0
`define TIMER0_CMP_PIN     1
`define TIMER0_RST_PIN     2
`define TIMER1_CLK_PIN     3
`define TIMER1_CMP_PIN     4
`define TIMER1_RST_PIN     5
`define PULSE0_PIN         6
`define PULSE1_PIN         7

`endif

// ---- include/gpio_port_pkg.sv ----
// types shared by the muxed io port and its bench
package gpio_port_pkg;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_s;

	// per-pin claim by a supporting module: drive enable and value
	typedef struct packed {
		logic [7:0] oe;
		logic [7:0] val;
	} module_drive_s;

	typedef enum logic [1:0] {
		run_e     = 2'b00,
		sw_stby_e = 2'b01,
		hw_stby_e = 2'b11
	} power_mode_e;

endpackage

// ---- hw/muxed_io_port.sv ----
// eight-bit general-purpose port shared with timers, pwm and host irq
`timescale 1ns/1ps
`include "gpio_port_defs.svh"

module muxed_io_port #(
	parameter int WIDTH = 8
) (
	input  wire logic                        ref_clk,        // 40 MHz clock
	input  wire logic                        reset,          // sync, high
	input  wire gpio_port_pkg::reg_req_s     bus_req,        // register req
	output logic [WIDTH-1:0]                 bus_rdata,      // read data
	input  wire gpio_port_pkg::power_mode_e  power_mode,     // standby state
	input  wire logic                        single_chip,    // mode 3 select
	input  wire logic                        host_iface_enable, // system_control_reg bit
	input  wire logic [1:0]                  pulse_width_out,   // pwm1..0
	input  wire logic [1:0]                  pulse_width_oe,    // pwm enables
	input  wire logic [1:0]                  timer_compare_out, // tmo1..0
	input  wire logic [1:0]                  timer_compare_oe,  // os bits !=0
	input  wire logic [2:0]                  host_irq_out,   // irq 11,1,12
	input  wire logic [WIDTH-1:0]            pin_in,         // pin levels
	output logic [WIDTH-1:0]                 pin_out,        // pin drive val
	output logic [WIDTH-1:0]                 pin_oe_n,       // low = driving
	output logic [1:0]                       timer_counter_reset_in, // timer_counter_reset_in
	output logic [1:0]                       timer_ext_clock_in,     // timer_ext_clock_in
	output logic                             slave_mode,     // host active
	output logic                             module_reset    // standby init
);

	// pin map of the port:
	//   pin 0  general io, timer 0 external clock input
	//   pin 1  general io, timer 0 compare output
	//   pin 2  general io, timer 0 counter reset input
	//   pin 3  general io or host irq, timer 1 external clock input
	//   pin 4  general io or host irq, timer 1 compare output
	//   pin 5  general io or host irq, timer 1 counter reset input
	//   pin 6  general io, pwm 0 output
	//   pin 7  general io, pwm 1 output
	// timer inputs are plain taps; only module outputs enter the drive
	// priority, so an input role never disturbs a general output

	localparam int IRQ_LO   = `HOST_IRQ_LO_PIN;
	localparam int IRQ_HI   = `HOST_IRQ_HI_PIN;
	localparam int IRQ_PINS = IRQ_HI - IRQ_LO + 1;
	localparam int ROLES    = 8;

	// every timer and pwm pin role, listed so that one loop can check them all
	localparam int ROLE_PIN [ROLES] = '{
		`TIMER0_CLK_PIN,
		`TIMER0_CMP_PIN,
		`TIMER0_RST_PIN,
		`TIMER1_CLK_PIN,
		`TIMER1_CMP_PIN,
		`TIMER1_RST_PIN,
		`PULSE0_PIN,
		`PULSE1_PIN
	};

	// the pin map is wired for eight pins; another width would leave
	// timer and host irq roles without a pin
	if (WIDTH != 8) begin : g_width_check
		$error("muxed_io_port supports only an eight-pin port");
	end

	if (IRQ_PINS != `HOST_IRQ_PINS) begin : g_irq_count_check
		$error("host irq pin range must match the irq output count");
	end

	if (IRQ_LO < 0 || IRQ_HI >= WIDTH) begin : g_irq_range_check
		$error("host irq pins lie outside the port");
	end

	// the register constants are written for the port width
	if ($bits(`PIN_DIRECTION_RST) != WIDTH) begin : g_dir_rst_check
		$error("direction reset value does not match the port width");
	end

	if ($bits(`PIN_DATA_RST) != WIDTH) begin : g_data_rst_check
		$error("data reset value does not match the port width");
	end

	if ($bits(`DIRECTION_READ_VAL) != WIDTH) begin : g_dir_read_check
		$error("direction read value does not match the port width");
	end

	if ($bits(bus_req.addr) != `PORT_ADDR_W) begin : g_addr_check
		$error("register address width does not match the decode");
	end

	// two roles on one pin would give the drive mux two owners
	for (genvar r = 0; r < ROLES; r++) begin : g_role_check
		if (ROLE_PIN[r] < 0 || ROLE_PIN[r] >= WIDTH) begin : g_range
			$error("pin role lies outside the port");
		end
		for (genvar s = r + 1; s < ROLES; s++) begin : g_pair
			if (ROLE_PIN[r] == ROLE_PIN[s]) begin : g_clash
				$error("two pin roles share one pin");
			end
		end
	end

	// register state and its next values
	logic [WIDTH-1:0] pin_direction_reg;
	logic [WIDTH-1:0] pin_data_reg;
	logic [WIDTH-1:0] next_pin_direction_reg;
	logic [WIDTH-1:0] next_pin_data_reg;
	logic [WIDTH-1:0] next_bus_rdata;

	// bus decode
	logic             dir_hit;
	logic             data_hit;
	logic             dir_write;
	logic             data_write;
	logic             dir_read;
	logic             data_read;

	// operating state
	logic             hw_stby;
	logic             sw_stby;

	// per-pin views built in the pin loop
	logic [WIDTH-1:0] read_view;
	logic [WIDTH-1:0] irq_sel;
	logic [WIDTH-1:0] irq_val;
	gpio_port_pkg::module_drive_s claim;
	gpio_port_pkg::module_drive_s pin_drive;

	assign hw_stby = (power_mode == gpio_port_pkg::hw_stby_e);
	assign sw_stby = (power_mode == gpio_port_pkg::sw_stby_e);

	// slave mode needs both the enable bit and single-chip operation
	assign slave_mode = host_iface_enable & single_chip;

	// supporting modules are held in init during any standby, so their
	// claims vanish and the registers take the pins back
	assign module_reset = sw_stby | hw_stby;

	// timer inputs always see the pin level, whatever the direction;
	// each timer decides itself whether it uses the tap
	assign timer_ext_clock_in[0]     = pin_in[`TIMER0_CLK_PIN];
	assign timer_ext_clock_in[1]     = pin_in[`TIMER1_CLK_PIN];
	assign timer_counter_reset_in[0] = pin_in[`TIMER0_RST_PIN];
	assign timer_counter_reset_in[1] = pin_in[`TIMER1_RST_PIN];

	// resulting pin function, per pin:
	//   claim  slave  dir   drives   value
	//   1      -      -     yes      module output
	//   0      1      1     yes      host irq, pins 3 to 5 only
	//   0      -      1     yes      data register bit
	//   0      -      0     no       input, level read back
	// the read mux ignores the claim and follows the direction bit alone,
	// so a claimed pin with direction 0 reads back the module's own level
	// pin outputs are combinational so a module claim reaches the pin in
	// the same cycle; the far side must not sample them mid-cycle
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_pin
			logic own_oe;
			logic own_val;

			// which supporting module output, if any, may claim this pin
			always_comb begin
				own_oe  = 1'b0;
				own_val = 1'b0;
				case (g)
					`PULSE1_PIN: begin
						own_oe  = pulse_width_oe[1];
						own_val = pulse_width_out[1];
					end
					`PULSE0_PIN: begin
						own_oe  = pulse_width_oe[0];
						own_val = pulse_width_out[0];
					end
					`TIMER1_CMP_PIN: begin
						own_oe  = timer_compare_oe[1];
						own_val = timer_compare_out[1];
					end
					`TIMER0_CMP_PIN: begin
						own_oe  = timer_compare_oe[0];
						own_val = timer_compare_out[0];
					end
					default: begin
						own_oe  = 1'b0;
						own_val = 1'b0;
					end
				endcase
			end

			// a claim only counts while the modules are out of init
			assign claim.oe[g]  = own_oe & ~module_reset;
			assign claim.val[g] = own_val;

			// host irq takes the general output only where direction is 1
			if (g >= IRQ_LO && g <= IRQ_HI) begin : g_irq
				assign irq_sel[g] = slave_mode & pin_direction_reg[g];
				assign irq_val[g] = host_irq_out[g - IRQ_LO];
			end else begin : g_gpio
				assign irq_sel[g] = 1'b0;
				assign irq_val[g] = 1'b0;
			end

			// drive priority: module claim, then host irq, then registers
			assign pin_drive.oe[g] = claim.oe[g] | pin_direction_reg[g];
			assign pin_drive.val[g] = claim.oe[g] ? claim.val[g]
				: irq_sel[g] ? irq_val[g]
				: pin_data_reg[g];

			// outputs read the stored bit, inputs the live level; claimed
			// pins follow their direction bit like any other pin
			assign read_view[g] = pin_direction_reg[g]
				? pin_data_reg[g]
				: pin_in[g];
		end
	endgenerate

	assign pin_out  = pin_drive.val;
	assign pin_oe_n = ~pin_drive.oe;

	// address decode; anything else reads as zero and writes nowhere
	assign dir_hit    = (bus_req.addr == `PIN_DIRECTION_ADDR);
	assign data_hit   = (bus_req.addr == `PIN_DATA_ADDR);
	assign dir_write  = bus_req.wr & dir_hit;
	assign data_write = bus_req.wr & data_hit;
	assign dir_read   = bus_req.rd & dir_hit;
	assign data_read  = bus_req.rd & data_hit;

	// standby handling in short:
	//   reset and hardware standby clear both registers
	//   software standby keeps both registers and only drops the claims
	//   leaving hardware standby finds every unclaimed pin an input again
	// a write during hardware standby is lost on purpose, since the
	// registers must come out of standby cleared

	// direction register
	always_comb begin
		next_pin_direction_reg = pin_direction_reg;
		if (dir_write)
			next_pin_direction_reg = bus_req.wdata;
		if (hw_stby)
			next_pin_direction_reg = `PIN_DIRECTION_RST;
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			pin_direction_reg <= `PIN_DIRECTION_RST;
		else
			pin_direction_reg <= next_pin_direction_reg;
	end

	// data register: same life as the direction register
	always_comb begin
		next_pin_data_reg = pin_data_reg;
		if (data_write)
			next_pin_data_reg = bus_req.wdata;
		if (hw_stby)
			next_pin_data_reg = `PIN_DATA_RST;
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			pin_data_reg <= `PIN_DATA_RST;
		else
			pin_data_reg <= next_pin_data_reg;
	end

	// the direction bits never read back, so software that changes one
	// pin at a time has to keep its own copy of the direction byte
	always_comb begin
		next_bus_rdata = `UNMAPPED_READ_VAL;
		if (dir_read)
			next_bus_rdata = `DIRECTION_READ_VAL;
		else if (data_read)
			next_bus_rdata = read_view;
	end

	// read data stand for one cycle only, then fall back to zero; a read
	// in the same cycle as a write to the data register returns the old
	// value, since the view is taken from the registers before the edge
	always_ff @(posedge ref_clk) begin
		if (reset)
			bus_rdata <= `UNMAPPED_READ_VAL;
		else
			bus_rdata <= next_bus_rdata;
	end

endmodule // muxed_io_port

// ---- verif/pin_load.sv ----
// far-side circuitry: drives input pins, follows the port where it drives
`timescale 1ns/1ps
module pin_load (
	input  wire logic [7:0] pin_out,  // port drive value
	input  wire logic [7:0] pin_oe_n, // low = port drives
	input  wire logic [7:0] ext,      // level the far side applies
	output logic      [7:0] pin_in    // resolved pin level
);
	// no pull-ups here: an undriven pin shows whatever the far side applies
	assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule // pin_load

// ---- verif/gpio_port_chk.sv ----
// assertions on the muxed io port pins and register reads
`timescale 1ns/1ps
module gpio_port_chk (
	input wire logic                      ref_clk,           // port clock
	input wire logic                      reset,             // sync, high
	input wire logic                      slave_mode,        // host active
	input wire logic                      module_reset,      // standby init
	input wire gpio_port_pkg::reg_req_s   bus_req,           // register req
	input wire gpio_port_pkg::power_mode_e power_mode,       // standby state
	input wire logic [1:0]                pulse_width_out,   // pwm values
	input wire logic [1:0]                pulse_width_oe,    // pwm enables
	input wire logic [1:0]                timer_compare_out, // timer values
	input wire logic [1:0]                timer_compare_oe,  // timer enables
	input wire logic [2:0]                host_irq_out,      // host irq
	input wire logic [7:0]                bus_rdata,         // read data
	input wire logic [7:0]                pin_in,            // pin levels
	input wire logic [7:0]                pin_out,           // drive value
	input wire logic [7:0]                pin_oe_n           // low = driving
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence rd_at(a);
		bus_req.rd && bus_req.addr == a;
	endsequence
	sequence in_hw;
		power_mode == gpio_port_pkg::hw_stby_e [*2];
	endsequence
	dir_write_a: assert property (
		bus_req.wr && bus_req.addr == 16'hffb5 &&
		power_mode == gpio_port_pkg::run_e |=> {pin_oe_n[2], pin_oe_n[0]}
		== ~$past({bus_req.wdata[2], bus_req.wdata[0]})) else $error("dir");
	dir_read_a: assert property (
		rd_at(16'hffb5) |=> bus_rdata == 8'hff) else $error("dir read");
	hw_clear_a: assert property (
		in_hw |-> pin_oe_n == 8'hff) else $error("hw standby");
	sw_keep_a: assert property (
		power_mode == gpio_port_pkg::sw_stby_e &&
		$past(power_mode) == gpio_port_pkg::sw_stby_e && !$past(bus_req.wr)
		|-> $stable(pin_oe_n)) else $error("sw standby");
	read_mix_a: assert property (
		rd_at(16'hffb7) |=> bus_rdata[0] ==
		$past(pin_oe_n[0] ? pin_in[0] : pin_out[0])) else $error("rd");
	rd_idle_a: assert property (
		!bus_req.rd |=> bus_rdata == 8'h00) else $error("idle rdata");
	pwm_claim_a: assert property (
		pulse_width_oe[0] && !module_reset |->
		!pin_oe_n[6] && pin_out[6] == pulse_width_out[0]) else $error("pw");
	tmo_claim_a: assert property (
		timer_compare_oe[1] && !module_reset |->
		!pin_oe_n[4] && pin_out[4] == timer_compare_out[1]) else $error("tm");
	irq_pin_a: assert property (
		slave_mode && !pin_oe_n[3] |->
		pin_out[3] == host_irq_out[0]) else $error("irq pin");
endmodule // gpio_port_chk
bind muxed_io_port gpio_port_chk gpio_port_chk_i (
	.ref_clk(ref_clk),
	.reset(reset),
	.slave_mode(slave_mode),
	.module_reset(module_reset),
	.bus_req(bus_req),
	.power_mode(power_mode),
	.pulse_width_out(pulse_width_out),
	.pulse_width_oe(pulse_width_oe),
	.timer_compare_out(timer_compare_out),
	.timer_compare_oe(timer_compare_oe),
	.host_irq_out(host_irq_out),
	.bus_rdata(bus_rdata),
	.pin_in(pin_in),
	.pin_out(pin_out),
	.pin_oe_n(pin_oe_n)
);

// ---- verif/eight_bit_muxed_io_port_tb.sv ----
// self-checking bench for the muxed io port
`timescale 1ns/1ps
module eight_bit_muxed_io_port_tb;
	logic ref_clk = 0, reset = 1, single_chip = 0, host_iface_enable = 0;
	gpio_port_pkg::reg_req_s bus_req = '0;
	gpio_port_pkg::power_mode_e power_mode = gpio_port_pkg::run_e;
	logic [1:0] pulse_width_out = 0, pulse_width_oe = 0, timer_compare_out = 0;
	logic [1:0] timer_compare_oe = 0, timer_counter_reset_in, timer_ext_clock_in;
	logic [2:0] host_irq_out = 3'h5;
	logic [7:0] bus_rdata, pin_in, pin_out, pin_oe_n, ext = 8'h3c;
	logic slave_mode, module_reset;
	int fail_count = 0, compares = 0;
	muxed_io_port muxed_io_port_i (
		.ref_clk(ref_clk),
		.reset(reset),
		.bus_req(bus_req),
		.bus_rdata(bus_rdata),
		.power_mode(power_mode),
		.single_chip(single_chip),
		.host_iface_enable(host_iface_enable),
		.pulse_width_out(pulse_width_out),
		.pulse_width_oe(pulse_width_oe),
		.timer_compare_out(timer_compare_out),
		.timer_compare_oe(timer_compare_oe),
		.host_irq_out(host_irq_out),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe_n(pin_oe_n),
		.timer_counter_reset_in(timer_counter_reset_in),
		.timer_ext_clock_in(timer_ext_clock_in),
		.slave_mode(slave_mode),
		.module_reset(module_reset)
	);
	pin_load pin_load_i (
		.pin_out(pin_out),
		.pin_oe_n(pin_oe_n),
		.ext(ext),
		.pin_in(pin_in)
	);
	always #12.5 ref_clk = ~ref_clk;
	task ck(input logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk) bus_req <= {a, d, 2'b10};
		@(posedge ref_clk) bus_req.wr <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge ref_clk) bus_req <= {a, 8'h00, 2'b01};
		@(posedge ref_clk) bus_req.rd <= 1'b0;
		@(negedge ref_clk) ck(bus_rdata, e);
	endtask
	task wrap_up;
		if (fail_count == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task s_regs;
		wr(16'hffb5, 8'hff);
		@(negedge ref_clk) ck(pin_oe_n, 8'h00);
		rd(16'hffb5, 8'hff);
		rd(16'hffb6, 8'h00);
		wr(16'hffb7, 8'ha5);
		wr(16'hffb5, 8'h0f);
		rd(16'hffb7, 8'h35);
	endtask
	task s_claim;
		@(posedge ref_clk) {pulse_width_oe, pulse_width_out} <= 4'h5;
		timer_compare_oe <= 2'h2;
		@(negedge ref_clk) ck(pin_oe_n, 8'ha0);
		ck(pin_out & 8'h50, 8'h40);
		rd(16'hffb7, 8'h65);
		@(posedge ref_clk) power_mode <= gpio_port_pkg::sw_stby_e;
		@(negedge ref_clk) ck(pin_oe_n, 8'hf0);
		ck({7'h0, module_reset}, 8'h01);
		@(posedge ref_clk) power_mode <= gpio_port_pkg::hw_stby_e;
		repeat (2) @(negedge ref_clk);
		ck(pin_oe_n, 8'hff);
		@(posedge ref_clk) power_mode <= gpio_port_pkg::run_e;
		@(negedge ref_clk) ck({4'h0, timer_counter_reset_in,
			timer_ext_clock_in}, 8'h0e);
		wr(16'hffb5, 8'hff);
		rd(16'hffb7, 8'h00);
	endtask
	task s_slave;
		@(posedge ref_clk) {single_chip, host_iface_enable} <= 2'h3;
		wr(16'hffb5, 8'hff);
		@(negedge ref_clk) ck({5'h0, pin_out[5:3]}, 8'h05);
		ck(pin_out & 8'h87, 8'h00);
		ck({7'h0, slave_mode}, 8'h01);
		@(posedge ref_clk) single_chip <= 1'b0;
		@(negedge ref_clk) ck(pin_out & 8'hbf, 8'h00);
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		s_regs();
		s_claim();
		s_slave();
		wrap_up();
	end
endmodule // eight_bit_muxed_io_port_tb
